// ---- rtl/ca_reference_defs.vh ----
`ifndef CA_REFERENCE_DEFS_VH
`define CA_REFERENCE_DEFS_VH

// ----------------------------------------
// mode register addresses
// ----------------------------------------
`define CA_REFERENCE_LEVEL_ADDR     6'h0c
`define FSP_CONTROL_ADDR            6'h0d

// ----------------------------------------
// field positions
// ----------------------------------------
`define CODE_MSB                    5
`define CODE_LSB                    0
`define RANGE_BIT                   6
`define BYTE_MODE_BIT               7
`define FSP_WRITE_BIT               6
`define FSP_OPERATE_BIT             7

// ----------------------------------------
// code limits and reset values
// ----------------------------------------
`define CODE_MAX                    6'h32
`define CODE_RESET                  6'h0d
`define RANGE_RESET                 1'h1
`define BYTE_MODE_RESET             1'h0
`define FSP_CONTROL_RESET           8'h00

`endif

// ---- rtl/setpoint_copy_store.v ----
`timescale 1ns/100ps

// ----------------------------------------
// two set-point copies of one 8-bit register
// ----------------------------------------
module setpoint_copy_store #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VALUE = 8'h4d
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             wr_en_i,
	input  wire             wr_sel_i,
	input  wire [WIDTH-1:0] wr_data_i,
	input  wire             rd_sel_i,
	input  wire             op_sel_i,
	output reg  [WIDTH-1:0] rd_data_o,
	output reg  [WIDTH-1:0] op_data_o
);

	reg [WIDTH-1:0] copy0;
	reg [WIDTH-1:0] copy1;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			copy0 <= RESET_VALUE;
			copy1 <= RESET_VALUE;
		end else if (wr_en_i) begin
			if (wr_sel_i)
				copy1 <= wr_data_i;
			else
				copy0 <= wr_data_i;
		end
	end

	// registered views; the operating view follows one cycle behind a write
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= RESET_VALUE;
			op_data_o <= RESET_VALUE;
		end else begin
			rd_data_o <= rd_sel_i ? copy1 : copy0;
			op_data_o <= op_sel_i ? copy1 : copy0;
		end
	end

endmodule // setpoint_copy_store

// ---- rtl/ca_reference_level.v ----
// ----------------------------------------
// Summary of operation
// - address 0ch selects this register for both writes and reads
// - bits 5..0 hold the code; codes 00h..32h valid, above reserved
// - bit 6 picks range: 0 lower, 1 upper
// - reset gives upper range, code 0dh, in both set-point copies
// - lower range 10.0..30.0 percent, upper up to 42.0 percent
// - a read drives register bits 7..0 onto data lines 7..0
// - reserved bits, including bit 7 outside byte mode, read back as zero
// - code write lands in copy 0 or 1 per write-select bit
// - writes and reads touch only the copy named by write-select
// - reference output uses only the copy named by operate-select
// - inactive copy is ignored; writing it leaves operation alone
// - range holds until overwritten or reset
// - bit 7 works only in byte-mode parts, else reserved
// - write-select is bit 6 of the set-point control register
// - operate-select is bit 7 of the set-point control register
// ----------------------------------------
`timescale 1ns/100ps
`include "ca_reference_defs.vh"

module ca_reference_level #(
	parameter BYTE_MODE = 0
) (
	input  wire       CLK_I,
	input  wire       RST_I,
	input  wire       MRW_I,
	input  wire       MRR_I,
	input  wire [5:0] MA_I,
	input  wire [7:0] OP_I,
	output reg  [7:0] DQ_O,
	output reg        DQ_VALID_O,
	output reg  [5:0] CA_REFERENCE_CODE_O,
	output reg        CA_REFERENCE_RANGE_SELECT_O,
	output reg        BYTE_MODE_BIT_O,
	output reg        SETPOINT_WRITE_SELECT_O,
	output reg        SETPOINT_OPERATE_SELECT_O
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	localparam [7:0] RESET_VALUE = {`BYTE_MODE_RESET, `RANGE_RESET, `CODE_RESET};

	function code_valid;
		input [5:0] code;
		begin
			code_valid = (code <= `CODE_MAX);
		end
	endfunction

	reg  [7:0] fsp_control;
	reg        read_pending;
	wire [7:0] copy_rd;
	wire [7:0] copy_op;
	wire       write_select = fsp_control[`FSP_WRITE_BIT];
	wire       operate_select = fsp_control[`FSP_OPERATE_BIT];
	wire       hit = (MA_I == `CA_REFERENCE_LEVEL_ADDR);
	// reserved code dropped, old value kept
	wire       write_ok = MRW_I & hit & code_valid(OP_I[`CODE_MSB:`CODE_LSB]);
	reg  [7:0] next_write;

	always @* begin
		next_write = OP_I;
		// bit 7 stored only in byte mode
		if (BYTE_MODE == 0)
			next_write[`BYTE_MODE_BIT] = 1'b0;
	end

	// ----------------------------------------
	// set-point control bits
	// ----------------------------------------
	// write and operate selects
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I)
			fsp_control <= `FSP_CONTROL_RESET;
		else if (MRW_I && MA_I == `FSP_CONTROL_ADDR)
			fsp_control <= OP_I;
	end

	// ----------------------------------------
	// two copies
	// ----------------------------------------
	// copy store
	setpoint_copy_store #(
		.WIDTH       (8),
		.RESET_VALUE (RESET_VALUE)
	) u_store (
		.clk_i     (CLK_I),
		.rst_i     (RST_I),
		.wr_en_i   (write_ok),
		.wr_sel_i  (write_select),
		.wr_data_i (next_write),
		.rd_sel_i  (write_select),
		.op_sel_i  (operate_select),
		.rd_data_o (copy_rd),
		.op_data_o (copy_op)
	);

	// ----------------------------------------
	// read path and applied level
	// ----------------------------------------
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			read_pending                <= 1'b0;
			DQ_O                        <= 8'h00;
			DQ_VALID_O                  <= 1'b0;
			CA_REFERENCE_CODE_O         <= `CODE_RESET;
			CA_REFERENCE_RANGE_SELECT_O <= `RANGE_RESET;
			BYTE_MODE_BIT_O             <= `BYTE_MODE_RESET;
			SETPOINT_WRITE_SELECT_O     <= 1'b0;
			SETPOINT_OPERATE_SELECT_O   <= 1'b0;
		end else begin
			// store read data is ready one cycle after the request
			read_pending <= MRR_I & hit;
			DQ_VALID_O   <= read_pending;
			// bits onto lines, reserved as zero
			if (read_pending)
				DQ_O <= copy_rd;
			else
				DQ_O <= 8'h00;
			CA_REFERENCE_CODE_O         <= copy_op[`CODE_MSB:`CODE_LSB];
			CA_REFERENCE_RANGE_SELECT_O <= copy_op[`RANGE_BIT];
			BYTE_MODE_BIT_O             <= copy_op[`BYTE_MODE_BIT];
			SETPOINT_WRITE_SELECT_O     <= write_select;
			SETPOINT_OPERATE_SELECT_O   <= operate_select;
		end
	end

endmodule // ca_reference_level

// ---- sim/ca_reference_level_monitor.sv ----
`timescale 1ns/100ps
module ca_reference_level_monitor(input wire CLK_I,RST_I,MRW_I,MRR_I,DQ_VALID_O,CA_REFERENCE_RANGE_SELECT_O,
	SETPOINT_WRITE_SELECT_O,SETPOINT_OPERATE_SELECT_O,input wire [5:0] MA_I,CA_REFERENCE_CODE_O,input wire [7:0] OP_I,DQ_O);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	wire rd = MRR_I && MA_I == 6'h0c;
	wire wr = MRW_I && MA_I == 6'h0c;
	// only a legal code aimed at the live copy may move the applied level
	wire act = OP_I[5:0] <= 6'h32 && SETPOINT_WRITE_SELECT_O == SETPOINT_OPERATE_SELECT_O;
	wire [6:0] ap = {CA_REFERENCE_RANGE_SELECT_O, CA_REFERENCE_CODE_O};
	sequence s_quiet; !MRW_I[*4]; endsequence
	sequence s_tail; !MRW_I[*2]; endsequence
	AST_RD_LAT: assert property (rd |-> ##2 DQ_VALID_O) else $error("late read");
	AST_RD_NONE: assert property (!rd |-> ##2 !DQ_VALID_O) else $error("stray read");
	AST_DQ_IDLE: assert property (!DQ_VALID_O |-> DQ_O == 8'h00) else $error("dq busy");
	AST_DQ_RSV: assert property (DQ_VALID_O |-> !DQ_O[7] && DQ_O[5:0] <= 6'h32) else $error("bad bits");
	AST_SEL: assert property (MRW_I && MA_I == 6'h0d |-> ##2
		{SETPOINT_OPERATE_SELECT_O, SETPOINT_WRITE_SELECT_O} == $past(OP_I[7:6], 2)) else $error("select");
	AST_APPLY: assert property (s_quiet ##1 wr && act ##1 s_tail |=> ap == $past(OP_I[6:0], 3)) else $error("apply");
	AST_KEEP: assert property (s_quiet ##1 wr && !act ##1 s_tail |=> $stable(ap)) else $error("keep");
	AST_HOLD: assert property ($changed(ap) |-> $past(MRW_I, 2) || $past(MRW_I, 3)) else $error("drift");
endmodule // ca_reference_level_monitor

// ---- sim/mr_controller_model.sv ----
`timescale 1ns/100ps
module mr_controller_model(input wire clk_i, output logic mrw_o = 0, mrr_o = 0,
	output logic [5:0] ma_o = 0, output logic [7:0] op_o = 0);
	task cmd(input logic w, r, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i) #1;
		{mrw_o, mrr_o, ma_o, op_o} = {w, r, a, d};
		@(posedge clk_i) #1;
		// released bus shows junk so stale values cannot pass
		{mrw_o, mrr_o, ma_o, op_o} = {2'b00, ~a, ~d};
	endtask
endmodule // mr_controller_model

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	logic CLK_I = 0, RST_I = 1, MRW_I, MRR_I, DQ_VALID_O, CA_REFERENCE_RANGE_SELECT_O, BYTE_MODE_BIT_O;
	logic SETPOINT_WRITE_SELECT_O, SETPOINT_OPERATE_SELECT_O, ws = 0, os = 0;
	logic [5:0] MA_I, CA_REFERENCE_CODE_O;
	logic [7:0] OP_I, DQ_O, v;
	logic [6:0] cpy[2];
	wire [9:0] outs = {BYTE_MODE_BIT_O, SETPOINT_OPERATE_SELECT_O, SETPOINT_WRITE_SELECT_O,
		CA_REFERENCE_RANGE_SELECT_O, CA_REFERENCE_CODE_O};
	integer seed = 32'h9c8aa483, bad_count = 0, cmp_count = 0, cyc = 0, i;
	always #2.5 CLK_I = ~CLK_I;
	ca_reference_level i_ca_reference_level(.*);
	mr_controller_model i_mc(.clk_i(CLK_I), .mrw_o(MRW_I), .mrr_o(MRR_I), .ma_o(MA_I), .op_o(OP_I));
	task chk(input logic [9:0] g, e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	function logic [6:0] nxt(input logic [6:0] old, input logic [7:0] d);
		return d[5:0] <= 6'h32 ? d[6:0] : old;
	endfunction
	task final_report;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge CLK_I) if (++cyc == 3000) begin
		bad_count++;
		final_report;
	end
	initial begin
		cpy = '{7'h4d, 7'h4d};
		repeat (6) @(posedge CLK_I);
		#1 RST_I = 0;
		chk(outs, 10'h04d);
		i_mc.cmd(1, 0, 6'h0c, 8'h32);
		i_mc.cmd(1, 0, 6'h0c, 8'h73);
		repeat (3) @(posedge CLK_I);
		#1 chk({CA_REFERENCE_RANGE_SELECT_O, CA_REFERENCE_CODE_O}, 7'h32);
		cpy[0] = 7'h32;
		$display("reset and boundary test done");
		for (i = 0; i < 80; i++) begin
			v = $random(seed);
			case (v[1:0])
				0: begin i_mc.cmd(1, 0, 6'h0d, v); ws = v[6]; os = v[7]; end
				1: begin i_mc.cmd(1, 0, 6'h0c, v); cpy[ws] = nxt(cpy[ws], v); end
				2: begin i_mc.cmd(0, 1, 6'h0c, v); @(posedge CLK_I) #1 chk({DQ_VALID_O, DQ_O}, {2'b10, cpy[ws]}); end
				3: begin i_mc.cmd(v[2], !v[2], 6'h0b, v); @(posedge CLK_I) #1 chk(DQ_VALID_O, 0); end
			endcase
			repeat (3) @(posedge CLK_I);
			#1 chk(outs, {1'b0, os, ws, cpy[os]});
		end
		$display("random test done");
		final_report;
	end
endmodule // testbench
bind ca_reference_level ca_reference_level_monitor i_mon(.*);
